// ===== logic/tan_pkg.sv
/*
  Shared constants for the table-access and nonvolatile-unlock link:
  operation codes, control register fields, key values, page layout and
  the controller's own register map.
  Assumes one 100 MHz clock shared by both ends of the link.
*/
// Function
// - table-low reaches program low word, EEPROM word
// - table-high alone reaches program upper byte
// - core never uses table-high on EEPROM
// - program addresses step two per word
// - word table-low read returns bits 15:0
// - byte table-low read picks byte by select
// - word table-high read zeroes phantom byte
// - byte table-high read, select one gives zero
// - page register bit 7 picks configuration space
// - configuration space: reads only, implemented areas
// - core writes 55, AA, then sets start
// - core idles two slots after setting start
// - start bit stays set until operation ends
// - core keeps unlock sequence uninterrupted
// - bulk erase clears whole EEPROM, no address
// - completion sets the done flag
// - core loads 4050 before bulk erase unlock
package tan_pkg;
  typedef enum logic [2:0] {
    OP_RDL = 3'h0,
    OP_RDH = 3'h1,
    OP_WTL = 3'h2,
    OP_WTH = 3'h3,
    OP_WCTL = 3'h4,
    OP_WKEY = 3'h5,
    OP_WPAG = 3'h6,
    OP_RCTL = 3'h7
  } tan_op_t;

  typedef enum logic [2:0] {
    CMD_RDL = 3'h0,
    CMD_RDH = 3'h1,
    CMD_WTL = 3'h2,
    CMD_WTH = 3'h3,
    CMD_NVM = 3'h4,
    CMD_BULK = 3'h5,
    CMD_RCTL = 3'h6
  } tan_cmd_t;

  localparam int CTL_WR = 15;
  localparam int CTL_WREN = 14;
  localparam int CTL_ERASE = 6;
  localparam logic [5:0] OPF_EE_BULK = 6'h10;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] BULK_CFG = 16'h4050;
  localparam logic [7:0] KEY1 = 8'h55;
  localparam logic [7:0] KEY2 = 8'hAA;
  localparam int PAGE_CFG_BIT = 7;
  localparam logic [7:0] EE_PAGE = 8'h7F;
  localparam logic [23:0] ERASED24 = 24'hFFFFFF;
  localparam logic [15:0] ERASED16 = 16'hFFFF;
  localparam logic [1:0] NOP_SLOTS = 2'h2;

  localparam logic [1:0] R_CMD = 2'h0;
  localparam logic [1:0] R_ADDR = 2'h1;
  localparam logic [1:0] R_WDATA = 2'h2;
  localparam logic [1:0] R_STAT = 2'h3;
  localparam int CMD_BYTE_BIT = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_RDATA_LSB = 16;
endpackage

// ===== logic/tan_if.sv
/*
  Link between the table-access/nonvolatile block and the core-side
  controller. Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface tan_if;
  import tan_pkg::*;
  logic req;
  tan_op_t op;
  logic bm;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic done;

  modport dev (input req, input op, input bm, input addr, input wdata, output ack, output rdata, output done);
  modport core (output req, output op, output bm, output addr, output wdata, input ack, input rdata, input done);
endinterface

// ===== logic/tan_nvm_dev.sv
/*
  Table-access path with program memory, data EEPROM, write latch,
  page register, control register and unlock logic.
  Assumes the core holds req until it sees ack, and keeps the unlock order.
*/
`timescale 1ns/100ps
module tan_nvm_dev
  import tan_pkg::*;
#(
  parameter int PMEM_WORDS = 64,
  parameter int EE_WORDS = 32,
  parameter int BUSY_CYCLES = 16,
  parameter logic [15:0] ID_ADDR = 16'h0000,
  parameter logic [23:0] ID_WORD = 24'h00A5C3 // arbitrary value
) (
  input wire logic REF_CLK, // 100 MHz clock
  input wire logic RST, // async reset, high
  tan_if.dev b, // link to core
  output logic NV_BUSY, // nonvolatile op running
  output logic NV_DONE // done flag
);
  localparam int PA = $clog2(PMEM_WORDS);
  localparam int EA = $clog2(EE_WORDS);
  localparam int CW = $clog2(BUSY_CYCLES + 1);

  typedef struct packed {
    logic [PMEM_WORDS-1:0][23:0] pmem;
    logic [EE_WORDS-1:0][15:0] eem;
    logic [7:0] page;
    logic [15:0] ctl;
    logic [1:0] key;
    logic [23:0] lat;
    logic [15:0] lat_addr;
    logic [7:0] lat_page;
    logic [CW-1:0] cnt;
    logic done;
    logic ack;
    logic [15:0] rdata;
  } tan_dev_st_t;

  localparam tan_dev_st_t S_RST = '{
    pmem: {PMEM_WORDS{ERASED24}},
    eem: {EE_WORDS{ERASED16}},
    page: 8'h00,
    ctl: CTL_RST,
    key: 2'h0,
    lat: ERASED24,
    lat_addr: 16'h0000,
    lat_page: 8'h00,
    cnt: '0,
    done: 1'b0,
    ack: 1'b0,
    rdata: 16'h0000
  };

  tan_dev_st_t s;
  tan_dev_st_t n;

  // ----------------------------------------------------------------
  // read data mapping
  // ----------------------------------------------------------------
  function automatic logic [15:0] rd_map(input logic [23:0] w, input logic hi, input logic bm, input logic bs);
    logic [15:0] r;
    r = 16'h0000;
    if (!hi) begin
      if (!bm) begin
        r = w[15:0];
      end else begin
        r = {8'h00, bs ? w[15:8] : w[7:0]};
      end
    end else begin
      if (!bm) begin
        r = {8'h00, w[23:16]};
      end else begin
        r = {8'h00, bs ? 8'h00 : w[23:16]};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic cfg;
    logic ee;
    logic hi;
    logic [PA-1:0] pi;
    logic [EA-1:0] ei;
    logic [PA-1:0] lpi;
    logic [EA-1:0] lei;
    cfg = s.page[PAGE_CFG_BIT];
    ee = (s.page == EE_PAGE);
    hi = (b.op == OP_RDH) || (b.op == OP_WTH);
    pi = b.addr[PA:1];
    ei = b.addr[EA:1];
    lpi = s.lat_addr[PA:1];
    lei = s.lat_addr[EA:1];
    n = s;
    n.ack = 1'b0;
    if (b.req && !s.ack) begin
      n.ack = 1'b1;
      n.rdata = 16'h0000;
      n.key = 2'h0;
      case (b.op)
        OP_RDL, OP_RDH: begin
          if (cfg) begin
            // only the identification word is implemented up there
            if (b.addr[15:1] == ID_ADDR[15:1]) begin
              n.rdata = rd_map(ID_WORD, hi, b.bm, b.addr[0]);
            end
          end else if (ee) begin
            if (!hi) begin
              n.rdata = rd_map({8'h00, s.eem[ei]}, 1'b0, b.bm, b.addr[0]);
            end
          end else begin
            n.rdata = rd_map(s.pmem[pi], hi, b.bm, b.addr[0]);
          end
        end
        OP_WTL, OP_WTH: begin
          if (!cfg) begin
            n.lat_addr = b.addr;
            n.lat_page = s.page;
            if (!hi) begin
              if (!b.bm) begin
                n.lat[15:0] = b.wdata;
              end else if (b.addr[0]) begin
                n.lat[15:8] = b.wdata[7:0];
              end else begin
                n.lat[7:0] = b.wdata[7:0];
              end
            end else if (!b.bm || !b.addr[0]) begin
              n.lat[23:16] = b.wdata[7:0];
            end
          end
        end
        OP_WCTL: begin
          // control is frozen while an operation runs
          if (s.cnt == '0) begin
            n.ctl = {1'b0, b.wdata[14:0]};
            if (b.wdata[CTL_WR] && b.wdata[CTL_WREN] && s.key == 2'h2) begin
              n.ctl[CTL_WR] = 1'b1;
              n.cnt = CW'(BUSY_CYCLES);
              n.done = 1'b0;
            end
          end
        end
        OP_WKEY: begin
          if (s.key == 2'h0 && b.wdata[7:0] == KEY1) begin
            n.key = 2'h1;
          end else if (s.key == 2'h1 && b.wdata[7:0] == KEY2) begin
            n.key = 2'h2;
          end
        end
        OP_WPAG: begin
          n.page = b.wdata[7:0];
        end
        OP_RCTL: begin
          n.rdata = s.ctl;
        end
        default: begin
          n.rdata = 16'h0000;
        end
      endcase
    end
    // completion last, so the done flag set wins over a clear
    if (s.cnt != '0) begin
      n.cnt = s.cnt - CW'(1);
      if (s.cnt == CW'(1)) begin
        if (s.ctl[CTL_ERASE] && s.ctl[5:0] == OPF_EE_BULK) begin
          n.eem = {EE_WORDS{ERASED16}};
        end else if (s.ctl[CTL_ERASE]) begin
          if (s.lat_page == EE_PAGE) begin
            n.eem[lei] = ERASED16;
          end else begin
            n.pmem[lpi] = ERASED24;
          end
        end else if (s.lat_page == EE_PAGE) begin
          n.eem[lei] = s.lat[15:0];
        end else begin
          n.pmem[lpi] = s.lat;
        end
        n.ctl[CTL_WR] = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= S_RST;
    end else begin
      s <= n;
    end
  end

  assign b.ack = s.ack;
  assign b.rdata = s.rdata;
  assign b.done = s.done;
  assign NV_BUSY = s.ctl[CTL_WR];
  assign NV_DONE = s.done;
endmodule

// ===== logic/tan_core_ctl.sv
/*
  Core-side controller: takes commands over AHB-Lite and plays them as
  table operations and unlock sequences on the link.
  Assumes a single AHB master; the slave never inserts wait states.
*/
`timescale 1ns/100ps
module tan_core_ctl
  import tan_pkg::*;
(
  input wire logic REF_CLK, // 100 MHz clock
  input wire logic RST, // async reset, high
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write
  input wire logic [2:0] HSIZE, // size, word only
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic HREADYOUT, // always ready
  output logic [31:0] HRDATA, // read data
  output logic HRESP, // always okay
  tan_if.core b // link to device
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_REQ = 3'b001,
    C_NOP = 3'b010,
    C_POLL = 3'b011
  } tan_cst_t;

  typedef struct packed {
    tan_cst_t st;
    logic [2:0] cmd;
    logic bm;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0] step;
    logic [1:0] nop;
    logic refused;
    logic ap_valid;
    logic ap_wr;
    logic ap_hit;
    logic [1:0] ap_idx;
  } tan_core_st_t;

  tan_core_st_t s;
  tan_core_st_t n;
  logic [18:0] cur;

  // ----------------------------------------------------------------
  // sequence steps
  // ----------------------------------------------------------------
  function automatic logic [18:0] step_of(input logic [2:0] cmd, input logic [1:0] st,
                                          input logic [15:0] wd, input logic [7:0] pg);
    logic [15:0] cfg;
    logic [18:0] r;
    cfg = (cmd == CMD_BULK) ? BULK_CFG : wd;
    r = {OP_RCTL, 16'h0000};
    if (cmd <= CMD_WTH) begin
      r = (st == 2'h0) ? {OP_WPAG, 8'h00, pg} : {cmd, wd};
    end else if (cmd == CMD_NVM || cmd == CMD_BULK) begin
      case (st)
        2'h0: r = {OP_WCTL, 1'b0, cfg[14:0]};
        2'h1: r = {OP_WKEY, 8'h00, KEY1};
        2'h2: r = {OP_WKEY, 8'h00, KEY2};
        default: r = {OP_WCTL, 1'b1, cfg[14:0]};
      endcase
    end
    return r;
  endfunction

  assign cur = step_of(s.cmd, s.step, s.wdata, s.addr[23:16]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic last;
    logic [2:0] c;
    n = s;
    c = HWDATA[2:0];
    last = (s.cmd == CMD_RCTL) || (s.cmd <= CMD_WTH && s.step == 2'h1) || (s.step == 2'h3);
    n.ap_valid = HSEL && HREADY && HTRANS[1];
    n.ap_wr = HWRITE;
    n.ap_hit = (HADDR[7:4] == 4'h0);
    n.ap_idx = HADDR[3:2];
    // commands while busy are dropped so a sequence runs unbroken
    if (s.ap_valid && s.ap_wr && s.ap_hit && s.st == C_IDLE) begin
      case (s.ap_idx)
        R_CMD: begin
          n.cmd = c;
          n.bm = HWDATA[CMD_BYTE_BIT];
          n.step = 2'h0;
          n.refused = (c == 3'h7) || ((c == CMD_RDH || c == CMD_WTH) && s.addr[23:16] == EE_PAGE);
          n.st = n.refused ? C_IDLE : C_REQ;
        end
        R_ADDR: n.addr = HWDATA[23:0];
        R_WDATA: n.wdata = HWDATA[15:0];
        default: n.refused = s.refused;
      endcase
    end
    case (s.st)
      C_REQ: begin
        if (b.ack) begin
          n.rdata = b.rdata;
          n.step = s.step + 2'h1;
          if (last) begin
            n.st = (s.cmd == CMD_NVM || s.cmd == CMD_BULK) ? C_NOP : C_IDLE;
            n.nop = NOP_SLOTS;
          end
        end
      end
      C_NOP: begin
        n.nop = s.nop - 2'h1;
        if (s.nop == 2'h1) begin
          n.st = C_POLL;
        end
      end
      C_POLL: begin
        if (b.ack) begin
          n.rdata = b.rdata;
          if (!b.rdata[CTL_WR]) begin
            n.st = C_IDLE;
          end
        end
      end
      // idle: leave the state to the command decode above
      default: n.nop = s.nop;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '{st: C_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  assign b.req = (s.st == C_REQ) || (s.st == C_POLL);
  assign b.op = (s.st == C_POLL) ? OP_RCTL : tan_op_t'(cur[18:16]);
  assign b.bm = s.bm;
  assign b.addr = s.addr[15:0];
  assign b.wdata = cur[15:0];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_comb begin
    HRDATA = 32'h00000000;
    if (s.ap_valid && !s.ap_wr && s.ap_hit) begin
      case (s.ap_idx)
        R_CMD: HRDATA = {23'h000000, s.bm, 5'h00, s.cmd};
        R_ADDR: HRDATA = {8'h00, s.addr};
        R_WDATA: HRDATA = {16'h0000, s.wdata};
        default: HRDATA = {s.rdata, 13'h0000, b.done, s.refused, s.st != C_IDLE};
      endcase
    end
  end
endmodule

// ===== bench/tan_props.sv
/*
  Checker on the table-access link, beside the interface joining both ends.
  Assumes one clock and an active high asynchronous reset.
*/
`timescale 1ns/100ps
module tan_props
  import tan_pkg::*;
#(
  parameter int BUSY_CYCLES = 16
) (
  input wire logic REF_CLK, // clock
  input wire logic RST, // async reset
  input wire logic req, // core request
  input wire tan_op_t op, // operation
  input wire logic bm, // byte mode
  input wire logic [15:0] addr, // offset
  input wire logic [15:0] wdata, // write data
  input wire logic ack, // device ack
  input wire logic [15:0] rdata, // read data
  input wire logic done, // done flag
  input wire logic NV_BUSY // op running
);
  // ------
  // helpers
  // ------
  logic [1:0] ks;
  int busy_cnt;
  wire take = req && !ack;

  // key progress seen on the link; any other request voids it
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ks <= 2'h0;
      busy_cnt <= 0;
    end else begin
      busy_cnt <= NV_BUSY ? busy_cnt + 1 : 0;
      if (take) begin
        ks <= (op == OP_WKEY && wdata[7:0] == KEY1) ? 2'h1 :
              (op == OP_WKEY && wdata[7:0] == KEY2 && ks == 2'h1) ? 2'h2 : 2'h0;
      end
    end
  end

  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // ------
  // properties
  // ------
  chk_ack_pulse: assert property (ack |=> !ack) else $error("ack held too long");
  chk_ack_timing: assert property (take |=> ack) else $error("ack missing after request");
  chk_ack_cause: assert property (ack |-> $past(take)) else $error("ack without request");
  chk_rdh_phantom: assert property (take && op == OP_RDH && !bm |=> rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  chk_rdh_byte_zero: assert property (take && op == OP_RDH && bm && addr[0] |=> rdata == 16'h0000)
    else $error("phantom byte select not zero");
  chk_rdata_hold: assert property (!$stable(rdata) |-> ack) else $error("read data moved without ack");
  chk_busy_length: assert property ($fell(NV_BUSY) |-> busy_cnt == BUSY_CYCLES)
    else $error("busy length wrong");
  chk_done_set: assert property ($fell(NV_BUSY) |-> done) else $error("done not set");
  chk_done_clear: assert property ($fell(done) |-> NV_BUSY) else $error("done cleared without start");
  chk_start_keys: assert property ($rose(NV_BUSY) |-> $past(ks) == 2'h2 && $past(op) == OP_WCTL)
    else $error("start without keys");
  chk_start_accept: assert property (take && op == OP_WCTL && wdata[CTL_WR] && wdata[CTL_WREN]
    && ks == 2'h2 && !NV_BUSY |=> NV_BUSY) else $error("unlocked start ignored");
  chk_nop_gap: assert property ($rose(NV_BUSY) |=> !req [*2])
    else $error("request inside start gap");
  cov_start: cover property ($rose(NV_BUSY));
  cov_phantom: cover property (take && op == OP_RDH && bm && addr[0]);
  cov_key: cover property (take && op == OP_WKEY);
endmodule

// ===== bench/table_access_nvm_unlock_tb.sv
/*
  Self-checking bench: software commands over AHB-Lite drive the controller,
  which plays table operations on the device.
  Assumes package and link interface are compiled first.
*/
`timescale 1ns/100ps
module table_access_nvm_unlock_tb;
  import tan_pkg::*;
  localparam logic [23:0] ID_VAL = 24'h3C5A96; // arbitrary value
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic HREADYOUT;
  logic [31:0] HRDATA;
  logic HRESP;
  logic NV_BUSY;
  logic NV_DONE;
  int fails = 0;
  int check_count = 0;
  logic [23:0] pw [4];
  logic [31:0] s;
  logic [15:0] rv;
  logic [15:0] ew;

  tan_if tan_if_inst ();
  // short busy count keeps the run brief
  tan_nvm_dev #(.BUSY_CYCLES(4), .ID_WORD(ID_VAL)) tan_nvm_dev_inst (.REF_CLK(REF_CLK), .RST(RST),
    .b(tan_if_inst.dev), .NV_BUSY(NV_BUSY), .NV_DONE(NV_DONE));
  tan_core_ctl tan_core_ctl_inst (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
    .HRDATA(HRDATA), .HRESP(HRESP), .b(tan_if_inst.core));
  tan_props #(.BUSY_CYCLES(4)) tan_props_inst (.REF_CLK(REF_CLK), .RST(RST), .req(tan_if_inst.req),
    .op(tan_if_inst.op), .bm(tan_if_inst.bm), .addr(tan_if_inst.addr), .wdata(tan_if_inst.wdata),
    .ack(tan_if_inst.ack), .rdata(tan_if_inst.rdata), .done(tan_if_inst.done), .NV_BUSY(NV_BUSY));

  always #5 REF_CLK = ~REF_CLK;

  // ------
  // tasks
  // ------
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 100);
    if (HREADYOUT !== 1'b1) begin
      fails++;
      close_out;
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    wait_rdy;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy;
    s = HRDATA;
  endtask

  // address and data first, then the command, then poll until idle
  task automatic run(input logic [8:0] c, input logic [31:0] a, input logic [15:0] d);
    int n;
    ahb(1'b1, 32'h4, a);
    ahb(1'b1, 32'h8, {16'h0, d});
    ahb(1'b1, 32'h0, {23'h0, c});
    n = 0;
    do begin
      ahb(1'b0, 32'hC, 32'h0);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    if (s[0] !== 1'b0) begin
      fails++;
      close_out;
    end
    rv = s[31:16];
  endtask

  // k: bit0 high space, k>=2 byte mode, k>=4 byte select one
  function automatic logic [15:0] exp_rd(input int k, input logic [23:0] w);
    case (k)
      0: return w[15:0];
      1, 3: return {8'h00, w[23:16]};
      2: return {8'h00, w[7:0]};
      4: return {8'h00, w[15:8]};
      default: return 16'h0000;
    endcase
  endfunction

  initial begin
    void'($urandom(32'h7D2B));
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    ahb(1'b0, 32'hC, 32'h0);
    chk("stat after reset", s[15:0] | s[31:16], 16'h0);
    chk("bus response", {15'h0, HRESP}, 16'h0);
    ahb(1'b0, 32'h40, 32'h0);
    chk("unmapped read", s[15:0], 16'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      pw[i] = (i == 0) ? 24'h000000 : 24'($urandom());
      run({1'b0, 5'h0, CMD_WTL}, 32'(2 * i), pw[i][15:0]);
      run({1'b0, 5'h0, CMD_WTH}, 32'(2 * i), {8'h0, pw[i][23:16]});
      run({1'b0, 5'h0, CMD_NVM}, 32'(2 * i), 16'h4001);
      chk("done flag", {15'h0, s[STAT_DONE]}, 16'h1);
      chk("done pin", {15'h0, NV_DONE}, 16'h1);
      chk("busy pin", {15'h0, NV_BUSY}, 16'h0);
    end
    foreach (pw[i]) begin
      for (int k = 0; k < 6; k++) begin
        run({k >= 2, 5'h0, k[0] ? CMD_RDH : CMD_RDL}, 32'(2 * i + int'(k >= 4)), 16'h0);
        chk("table read", rv & ((k inside {[2:4]}) ? 16'h00FF : 16'hFFFF), exp_rd(k, pw[i]));
      end
    end
    $display("test program space done");
    ew = 16'($urandom());
    run({1'b0, 5'h0, CMD_WTL}, {8'h0, EE_PAGE, 16'h0006}, ew);
    run({1'b0, 5'h0, CMD_NVM}, {8'h0, EE_PAGE, 16'h0006}, 16'h4001);
    run({1'b0, 5'h0, CMD_RDL}, {8'h0, EE_PAGE, 16'h0006}, 16'h0);
    chk("eeprom word", rv, ew);
    run({1'b0, 5'h0, CMD_RDH}, {8'h0, EE_PAGE, 16'h0006}, 16'h0);
    chk("eeprom high refused", {15'h0, s[STAT_REFUSED]}, 16'h1);
    run({1'b0, 5'h0, CMD_BULK}, 32'h0, BULK_CFG);
    run({1'b0, 5'h0, CMD_RDL}, {8'h0, EE_PAGE, 16'h0006}, 16'h0);
    chk("eeprom erased", rv, ERASED16);
    run({1'b0, 5'h0, CMD_RDL}, 32'h0, 16'h0);
    chk("program kept", rv, pw[0][15:0]);
    $display("test eeprom done");
    run({1'b0, 5'h0, CMD_WTL}, 32'h0080_0000, 16'h1234);
    run({1'b0, 5'h0, CMD_NVM}, 32'h0080_0000, 16'h4001);
    run({1'b0, 5'h0, CMD_RDL}, 32'h0080_0000, 16'h0);
    chk("id low", rv, ID_VAL[15:0]);
    run({1'b0, 5'h0, CMD_RDH}, 32'h0080_0000, 16'h0);
    chk("id high", rv, {8'h00, ID_VAL[23:16]});
    run({1'b0, 5'h0, CMD_RDL}, 32'h0080_0002, 16'h0);
    chk("config unimplemented", rv, 16'h0);
    run({1'b0, 5'h0, CMD_RDL}, 32'h0, 16'h0);
    chk("config write blocked", rv, pw[0][15:0]);
    run({1'b0, 5'h0, 3'h7}, 32'h0, 16'h0);
    chk("bad command refused", {15'h0, s[STAT_REFUSED]}, 16'h1);
    run({1'b0, 5'h0, CMD_RCTL}, 32'h0, 16'h0);
    chk("refused cleared", {15'h0, s[STAT_REFUSED]}, 16'h0);
    chk("control after op", rv, 16'h4001);
    $display("test config space done");
    close_out;
  end
endmodule
